// ===== core/pic_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic por_n,
	input wire logic watchdog_clear,
	input wire logic se0,
	input wire logic [4:0] endpoint_evt,
	input wire logic hub_evt,
	input wire logic dac_evt,
	input wire logic handshaked_parallel_port_evt,
	input wire logic i2c_evt,
	input wire pic_pkg::pic_bus_req_t bus,
	input wire pic_pkg::pic_core_t core,
	output logic [7:0] rdata,
	output pic_pkg::pic_call_t call_out,
	output logic watchdog_reset_flag,
	output logic start_vector_load
);
	import pic_pkg::*;
	pic_state_t s_r;
	pic_state_t s_nxt;
	logic [11:0] evt;
	logic [11:0] enab;
	logic [11:0] req;
	logic [3:0] win;
	logic found;
	logic tick_short;
	logic wdog_exp;
	logic st_write;
	always_comb begin
		enab = {s_r.gmask[6:3], s_r.emask[4:0], s_r.gmask[2:0]};
		req = s_r.pending & enab;
		win = 4'h0;
		found = 1'b0;
		for (int i = PIC_NSRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				win = 4'(i);
				found = 1'b1;
			end
		end
		tick_short = (s_r.tdiv == 16'(PIC_TICK_SHORT_CYC - 1));
		wdog_exp = (s_r.wdog == 25'(PIC_WATCH_CYC - 1));
		st_write = bus.wr && bus.addr == PIC_ADDR_STATUS;
	end
	always_comb begin
		s_nxt = s_r;
		s_nxt.call.call = 1'b0;
		s_nxt.call.restore = 1'b0;
		s_nxt.rdata = 8'h00;
		// ****************************************
		// Event sources
		// ****************************************
		s_nxt.se0_q = se0;
		evt = 12'h000;
		evt[PIC_SRC_BUSRST] = s_r.se0_q && !se0;
		s_nxt.tdiv = tick_short ? 16'h0000 : s_r.tdiv + 16'h0001;
		evt[PIC_SRC_SHORT] = tick_short;
		if (tick_short) begin
			s_nxt.tlong = s_r.tlong + 3'h1;
		end
		evt[PIC_SRC_LONG] = tick_short &&
			s_r.tlong == 3'(PIC_TICK_LONG_DIV - 1);
		evt[PIC_SRC_EP0 +: 5] = endpoint_evt;
		evt[PIC_SRC_HUB] = hub_evt;
		evt[PIC_SRC_HUB + 1] = dac_evt;
		evt[PIC_SRC_HUB + 2] = handshaked_parallel_port_evt;
		evt[PIC_SRC_HUB + 3] = i2c_evt;
		// ****************************************
		// Register writes
		// ****************************************
		if (bus.wr && bus.addr == PIC_ADDR_GLOBAL_MASK) begin
			s_nxt.gmask = bus.wdata & PIC_GLOBAL_WMASK;
		end
		if (bus.wr && bus.addr == PIC_ADDR_EP_MASK) begin
			s_nxt.emask = bus.wdata & PIC_EP_WMASK;
		end
		if (st_write) begin
			s_nxt.status[PIC_ST_RUN] = bus.wdata[PIC_ST_RUN];
			s_nxt.status[PIC_ST_RSVD] = bus.wdata[PIC_ST_RSVD];
			s_nxt.status[PIC_ST_SUSP] = bus.wdata[PIC_ST_SUSP];
			s_nxt.status[PIC_ST_POR] = bus.wdata[PIC_ST_POR];
			s_nxt.status[PIC_ST_BUSRST] = bus.wdata[PIC_ST_BUSRST];
			s_nxt.status[PIC_ST_WDR] = bus.wdata[PIC_ST_WDR];
		end
		if (evt[PIC_SRC_BUSRST]) begin
			s_nxt.status[PIC_ST_BUSRST] = 1'b1;
			s_nxt.boot = 1'b0;
		end
		// ****************************************
		// Global enable ops
		// ****************************************
		if (core.disable_interrupts_op) begin
			s_nxt.gie = 1'b0;
		end else if (core.enable_interrupts_op ||
			core.return_from_interrupt_op) begin
			s_nxt.gie = 1'b1;
		end
		if (core.return_from_interrupt_op) begin
			s_nxt.call.restore = 1'b1;
		end
		// ****************************************
		// Interrupt entry sequence
		// ****************************************
		case (s_r.phase)
		PIC_IDLE: begin
			if (found && s_r.gie && core.instr_done) begin
				s_nxt.gie = 1'b0;
				s_nxt.src = win;
				s_nxt.phase = PIC_CALL;
				s_nxt.cnt = 4'(PIC_CALL_CYCLES - 1);
				s_nxt.call.busy = 1'b1;
				s_nxt.call.call = 1'b1;
				s_nxt.call.vector = PIC_VEC_BASE +
					{9'h000, win, 1'b0};
				s_nxt.call.push_word = {core.carry_flag, core.zero_flag,
					core.pc};
			end
		end
		PIC_CALL: begin
			s_nxt.cnt = s_r.cnt - 4'h1;
			if (s_r.cnt == 4'h0) begin
				s_nxt.phase = PIC_JUMP;
				s_nxt.cnt = 4'(PIC_JMP_CYCLES - 1);
			end
		end
		PIC_JUMP: begin
			s_nxt.cnt = s_r.cnt - 4'h1;
			if (s_r.cnt == 4'h0) begin
				s_nxt.phase = PIC_IDLE;
				s_nxt.call.busy = 1'b0;
			end
		end
		default: begin
			s_nxt.phase = PIC_IDLE;
		end
		endcase
		// Set wins over take
		for (int i = 0; i < PIC_NSRC; i++) begin
			if (s_r.phase == PIC_IDLE && s_nxt.phase == PIC_CALL &&
				win == 4'(i)) begin
				s_nxt.pending[i] = 1'b0;
			end
			if (evt[i]) begin
				s_nxt.pending[i] = 1'b1;
			end
		end
		s_nxt.status[PIC_ST_PEND] = |(s_nxt.pending & enab);
		s_nxt.status[PIC_ST_IE] = s_nxt.gie;
		// ****************************************
		// Watchdog
		// ****************************************
		s_nxt.wdog = (watchdog_clear || wdog_exp) ? 25'h0 :
			s_r.wdog + 25'h1;
		// ****************************************
		// Read data
		// ****************************************
		if (bus.rd) begin
			case (bus.addr)
			PIC_ADDR_GLOBAL_MASK: s_nxt.rdata = s_r.gmask;
			PIC_ADDR_EP_MASK: s_nxt.rdata = s_r.emask;
			PIC_ADDR_STATUS: s_nxt.rdata = s_r.status;
			PIC_ADDR_PENDING_LO: s_nxt.rdata = s_r.pending[7:0];
			PIC_ADDR_PENDING_HI: s_nxt.rdata = {4'h0, s_r.pending[11:8]};
			default: s_nxt.rdata = 8'h00;
			endcase
		end
		// ****************************************
		// Watchdog reset: POR and bus reset flags kept, WDR set, masks, pending, enable and entry state cleared
		// ****************************************
		if (wdog_exp) begin
			s_nxt.status = PIC_STATUS_POR;
			s_nxt.status[PIC_ST_WDR] = 1'b1;
			s_nxt.status[PIC_ST_POR] = s_r.status[PIC_ST_POR];
			s_nxt.status[PIC_ST_BUSRST] = s_r.status[PIC_ST_BUSRST];
			s_nxt.gmask = PIC_MASK_RESET;
			s_nxt.emask = PIC_MASK_RESET;
			s_nxt.pending = 12'h000;
			s_nxt.gie = 1'b0;
			s_nxt.phase = PIC_IDLE;
			s_nxt.call = '0;
			s_nxt.call.vector = PIC_RESET_VEC;
		end
	end
	always_ff @(posedge clk) begin
		if (!por_n) begin
			s_r <= '0;
			s_r.status <= PIC_STATUS_POR;
			s_r.boot <= 1'b1;
		end else if (!rst_n) begin
			s_r <= '0;
			s_r.status <= PIC_STATUS_POR;
			s_r.status[PIC_ST_POR] <= s_r.status[PIC_ST_POR];
			s_r.status[PIC_ST_WDR] <= s_r.status[PIC_ST_WDR];
			s_r.status[PIC_ST_BUSRST] <= s_r.status[PIC_ST_BUSRST];
			s_r.boot <= s_r.boot;
		end else begin
			s_r <= s_nxt;
		end
	end
	always_ff @(posedge clk) begin
		if (!por_n || !rst_n) begin
			start_vector_load <= 1'b1;
		end else begin
			start_vector_load <= wdog_exp;
		end
	end
	assign rdata = s_r.rdata;
	assign call_out = s_r.call;
	assign watchdog_reset_flag = s_r.status[PIC_ST_WDR];
	// ****************************************
	// Assertions
	// ****************************************
	property p_take_clears;
		@(posedge clk) disable iff (!rst_n || !por_n)
		(s_r.phase == PIC_IDLE && found && s_r.gie && core.instr_done &&
			!wdog_exp && !evt[win]) |=> !s_r.gie && !s_r.pending[s_r.src];
	endproperty
	a_take_clears: assert property (p_take_clears)
		else $error("take did not clear enable and pending");
	property p_no_take_mid;
		@(posedge clk) disable iff (!rst_n || !por_n)
		(s_r.phase == PIC_IDLE && !core.instr_done) |=> !s_r.call.call;
	endproperty
	a_no_take_mid: assert property (p_no_take_mid)
		else $error("call issued mid instruction");
	property p_vector;
		@(posedge clk) disable iff (!rst_n || !por_n)
		s_r.call.call |-> s_r.call.vector == 14'(2 + 2 * s_r.src);
	endproperty
	a_vector: assert property (p_vector)
		else $error("wrong vector address");
	property p_latency;
		@(posedge clk) disable iff (!rst_n || !por_n || wdog_exp)
		$rose(s_r.call.busy) |-> s_r.call.busy [*8] ##7 s_r.call.busy
			##1 !s_r.call.busy;
	endproperty
	a_latency: assert property (p_latency)
		else $error("entry length not fifteen");
	property p_sense;
		@(posedge clk) disable iff (!rst_n || !por_n)
		s_r.status[PIC_ST_IE] == s_r.gie;
	endproperty
	a_sense: assert property (p_sense)
		else $error("status bit 2 mismatch");
	property p_rsvd;
		@(posedge clk) disable iff (!rst_n || !por_n)
		s_r.gmask[7] == 1'b0 && s_r.emask[7:5] == 3'h0;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved enable bit set");
	property p_return_from_interrupt_op;
		@(posedge clk) disable iff (!rst_n || !por_n)
		(core.return_from_interrupt_op && !core.disable_interrupts_op &&
			!wdog_exp) |=> s_r.gie && s_r.call.restore;
	endproperty
	a_return_from_interrupt_op: assert property (p_return_from_interrupt_op)
		else $error("return did not re-enable");
	property p_busrst;
		@(posedge clk) disable iff (!rst_n || !por_n)
		($past(s_r.se0_q) && !$past(se0) && !$past(wdog_exp)) |->
			s_r.pending[PIC_SRC_BUSRST] || s_r.call.busy;
	endproperty
	a_busrst: assert property (p_busrst)
		else $error("bus reset end not flagged");
	property p_wdr;
		@(posedge clk) disable iff (!rst_n || !por_n)
		wdog_exp |=> s_r.status[PIC_ST_WDR] && s_r.gmask == 8'h00 &&
			!s_r.status[PIC_ST_PEND];
	endproperty
	a_wdr: assert property (p_wdr)
		else $error("watchdog reset status wrong");
	c_take: cover property (@(posedge clk) s_r.call.call);
	c_nest: cover property (@(posedge clk)
		s_r.call.busy && core.enable_interrupts_op);
	c_wdog: cover property (@(posedge clk) wdog_exp);
	c_long: cover property (@(posedge clk) evt[PIC_SRC_LONG]);
endmodule
`default_nettype wire

// ===== core/pic_pkg.sv
package pic_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] PIC_ADDR_GLOBAL_MASK = 8'h20;
	localparam logic [7:0] PIC_ADDR_EP_MASK = 8'h21;
	localparam logic [7:0] PIC_ADDR_STATUS = 8'hff;
	localparam logic [7:0] PIC_ADDR_PENDING_LO = 8'hfc;
	localparam logic [7:0] PIC_ADDR_PENDING_HI = 8'hfd;
	localparam logic [7:0] PIC_GLOBAL_WMASK = 8'h7f;
	localparam logic [7:0] PIC_EP_WMASK = 8'h1f;
	localparam logic [7:0] PIC_MASK_RESET = 8'h00;
	localparam logic [7:0] PIC_STATUS_POR = 8'h11;
	// ****************************************
	// Status bit positions
	// ****************************************
	localparam int PIC_ST_RUN = 0;
	localparam int PIC_ST_RSVD = 1;
	localparam int PIC_ST_IE = 2;
	localparam int PIC_ST_SUSP = 3;
	localparam int PIC_ST_POR = 4;
	localparam int PIC_ST_BUSRST = 5;
	localparam int PIC_ST_WDR = 6;
	localparam int PIC_ST_PEND = 7;
	// ****************************************
	// Sources, vectors, timing
	// ****************************************
	localparam int PIC_NSRC = 12;
	localparam logic [13:0] PIC_VEC_BASE = 14'h0002;
	localparam logic [13:0] PIC_RESET_VEC = 14'h0000;
	localparam int PIC_CALL_CYCLES = 10;
	localparam int PIC_JMP_CYCLES = 5;
	localparam int PIC_CLK_KHZ = 50000;
	localparam int PIC_TICK_SHORT_US = 128;
	localparam int PIC_TICK_LONG_US = 1024;
	localparam int PIC_WATCH_MS = 8;
	localparam int PIC_TICK_SHORT_CYC = PIC_TICK_SHORT_US * PIC_CLK_KHZ / 1000;
	localparam int PIC_TICK_LONG_DIV = PIC_TICK_LONG_US / PIC_TICK_SHORT_US;
	localparam int PIC_WATCH_CYC = PIC_WATCH_MS * PIC_CLK_KHZ;
	// Source index order equals vector order (index 0 = vector 1)
	localparam int PIC_SRC_BUSRST = 0;
	localparam int PIC_SRC_SHORT = 1;
	localparam int PIC_SRC_LONG = 2;
	localparam int PIC_SRC_EP0 = 3;
	localparam int PIC_SRC_HUB = 8;
	typedef enum logic [1:0] {PIC_IDLE, PIC_CALL, PIC_JUMP} pic_phase_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pic_bus_req_t;
	typedef struct packed {
		logic disable_interrupts_op;
		logic enable_interrupts_op;
		logic return_from_interrupt_op;
		logic instr_done;
		logic carry_flag;
		logic zero_flag;
		logic [13:0] pc;
	} pic_core_t;
	typedef struct packed {
		logic call;
		logic [13:0] vector;
		logic [15:0] push_word;
		logic restore;
		logic busy;
	} pic_call_t;
	typedef struct packed {
		logic [7:0] gmask;
		logic [7:0] emask;
		logic [7:0] status;
		logic [11:0] pending;
		logic gie;
		logic [7:0] rdata;
		pic_phase_t phase;
		logic [3:0] cnt;
		logic [3:0] src;
		pic_call_t call;
		logic [15:0] tdiv;
		logic [2:0] tlong;
		logic [24:0] wdog;
		logic se0_q;
		logic boot;
	} pic_state_t;
endpackage

// ===== verif/pic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ei_req,
	input wire pic_pkg::pic_call_t call_in,
	output var pic_pkg::pic_core_t core
);
	import pic_pkg::*;
	// ****************************************
	// Instruction sequencer with short service routine
	// ****************************************
	logic [2:0] left_r;
	logic [5:0] isr_r;
	logic in_isr_r;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			core <= '0;
			left_r <= '0;
			isr_r <= '0;
			in_isr_r <= 1'b0;
		end else begin
			core.enable_interrupts_op <= ei_req;
			core.return_from_interrupt_op <= 1'b0;
			if (call_in.busy) begin
				// Call and jump run, no boundary
				core.instr_done <= 1'b0;
				core.pc <= call_in.vector;
				isr_r <= 6'h14;
				in_isr_r <= 1'b1;
			end else begin
				core.instr_done <= (left_r == 3'h0);
				if (left_r == 3'h0) begin
					left_r <= {1'b0, core.pc[1:0]} + 3'h1;
					core.pc <= core.pc + 14'h1;
					core.carry_flag <= core.pc[0];
					core.zero_flag <= core.pc[1];
				end else begin
					left_r <= left_r - 3'h1;
				end
				if (in_isr_r && isr_r != 6'h0) begin
					isr_r <= isr_r - 6'h1;
				end else if (in_isr_r && left_r == 3'h0) begin
					core.return_from_interrupt_op <= 1'b1;
					in_isr_r <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/tb_prioritized_interrupt_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_prioritized_interrupt_controller;
	import pic_pkg::*;
	logic clk, rst_n, por_n, se0, ei_r;
	logic [11:0] evt_r;
	logic [7:0] rdata;
	logic wd_flag, start_vector_load, rd_d;
	logic [31:0] seed;
	pic_bus_req_t bus;
	pic_core_t core, prev_r;
	pic_call_t call_out;
	int err_total, cmp_count, cyc, t_last, t_prev, bcnt, ncall, nrest;
	logic [15:0] rq[$];
	logic [15:0] vq[$];
	always #10 clk = ~clk;
	pic_ctrl DUT (.clk(clk), .rst_n(rst_n), .por_n(por_n),
		.watchdog_clear(1'b1), .se0(se0), .endpoint_evt(evt_r[7:3]),
		.hub_evt(evt_r[8]), .dac_evt(evt_r[9]),
		.handshaked_parallel_port_evt(evt_r[10]), .i2c_evt(evt_r[11]),
		.bus(bus), .core(core), .rdata(rdata), .call_out(call_out),
		.watchdog_reset_flag(wd_flag),
		.start_vector_load(start_vector_load));
	pic_core_model partner (.clk(clk), .rst_n(rst_n), .ei_req(ei_r),
		.call_in(call_out), .core(core));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("mismatches %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		rq.push_back({8'h00, e});
		@(posedge clk);
		bus.rd <= 1'b0;
	endtask
	task automatic wait_q;
		int n;
		n = 0;
		while (vq.size() != 0 && n < 60000) begin
			@(posedge clk);
			n++;
		end
		if (vq.size() != 0)
			chk(16'(vq.size()), 16'h0);
		repeat (60) @(posedge clk);
	endtask
	// ****************************************
	// Output monitor
	// ****************************************
	always @(posedge clk) begin
		rd_d <= bus.rd;
		prev_r <= core;
		cyc++;
	end
	always @(negedge clk) begin
		logic [15:0] e;
		if (rd_d)
			chk({8'h00, rdata}, rq.pop_front());
		if (call_out.call) begin
			e = vq.size() ? vq.pop_front() : 16'hffff;
			chk({2'b00, call_out.vector}, e);
			chk(call_out.push_word,
				{prev_r.carry_flag, prev_r.zero_flag, prev_r.pc});
			t_prev = t_last;
			t_last = cyc;
			ncall++;
		end
		if (call_out.restore)
			nrest++;
		if (call_out.busy) begin
			bcnt++;
		end else if (bcnt != 0) begin
			chk(16'(bcnt), 16'(PIC_CALL_CYCLES + PIC_JMP_CYCLES));
			bcnt = 0;
		end
	end
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		results;
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		clk = 0;
		rst_n = 0;
		por_n = 0;
		se0 = 0;
		ei_r = 0;
		evt_r = '0;
		bus = '0;
		seed = 32'h731dba34;
		repeat (6) @(posedge clk);
		chk(16'(start_vector_load), 16'h1);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		rd(8'h20, 8'h00);
		rd(8'h21, 8'h00);
		rd(8'hff, 8'h11);
		chk(16'(start_vector_load), 16'h0);
		chk(16'(wd_flag), 16'h0);
		rd(8'h40, 8'h00);
		repeat (4) begin
			seed = lfsr(seed);
			wr(8'h20, seed[7:0]);
			rd(8'h20, seed[7:0] & 8'h7f);
			wr(8'h21, seed[15:8]);
			rd(8'h21, seed[15:8] & 8'h1f);
		end
		wr(8'h20, 8'h69);
		wr(8'h21, 8'h1f);
		@(posedge clk) evt_r <= 12'hff8;
		@(posedge clk) evt_r <= '0;
		rd(8'hfc, 8'hf8);
		rd(8'hfd, 8'h0f);
		rd(8'hff, 8'h91);
		for (int i = 3; i < 12; i++)
			if (i != 9)
				vq.push_back(16'(2 + 2 * i));
		@(posedge clk) ei_r <= 1'b1;
		@(posedge clk) ei_r <= 1'b0;
		wait_q;
		rd(8'hfd, 8'h02);
		vq.push_back(16'h0014);
		wr(8'h20, 8'h79);
		wait_q;
		rd(8'hff, 8'h15);
		wr(8'h20, 8'h01);
		se0 <= 1'b1;
		repeat (30) @(posedge clk);
		vq.push_back(16'h0002);
		se0 <= 1'b0;
		wait_q;
		rd(8'hff, 8'h35);
		repeat (3) vq.push_back(16'h0004);
		wr(8'h20, 8'h02);
		wait_q;
		chk(16'(t_last - t_prev > 6395 && t_last - t_prev < 6405), 16'h1);
		vq.push_back(16'h0006);
		wr(8'h20, 8'h04);
		wait_q;
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk) rst_n <= 1'b1;
		rd(8'h20, 8'h00);
		rd(8'h21, 8'h00);
		chk(16'(nrest), 16'(ncall));
		results;
	end
endmodule
`default_nettype wire
